// ### hdl/pdl_cfg.svh
`ifndef PDL_CFG_SVH
`define PDL_CFG_SVH

// Command nibble codes
`define PDL_CMD_NOP        4'h0
`define PDL_CMD_WR_INPUT   4'h1
`define PDL_CMD_UPD_DAC    4'h2
`define PDL_CMD_WR_UPD     4'h3
`define PDL_CMD_PWR_MODE   4'h4
`define PDL_CMD_LOAD_MASK  4'h5

// Frame field positions
`define PDL_CMD_MSB        23
`define PDL_CMD_LSB        20
`define PDL_ADDR_B_BIT     19
`define PDL_ADDR_A_BIT     16
`define PDL_DATA_MSB       15
`define PDL_DATA_LSB       4

// Power mode field positions, channel A then channel B
`define PDL_PD_A_LSB       0
`define PDL_PD_B_LSB       6

// Strobe mask bit positions, channel A then channel B
`define PDL_MASK_A_BIT     0
`define PDL_MASK_B_BIT     3

// Power mode codes
`define PDL_PD_NORMAL      2'h0
`define PDL_PD_1K          2'h1
`define PDL_PD_100K        2'h2
`define PDL_PD_OPEN        2'h3

// Reset values
`define PDL_MASK_RESET     4'h0
`define PDL_CODE_RESET     12'h000

// Timing, clock period and derived cycle counts
`define PDL_CLK_PERIOD_NS  8
`define PDL_PWRUP_TIME_NS  4500
`define PDL_PWRUP_CYCLES   ((`PDL_PWRUP_TIME_NS + `PDL_CLK_PERIOD_NS - 1) / `PDL_CLK_PERIOD_NS)
`define PDL_TIE_TIME_NS    2000
`define PDL_TIE_CYCLES     ((`PDL_TIE_TIME_NS + `PDL_CLK_PERIOD_NS - 1) / `PDL_CLK_PERIOD_NS)
`define PDL_CNT_W          10

`endif

// ### hdl/pdl_chan.sv
`timescale 1ns/1ns
`include "pdl_cfg.svh"
// One converter channel: input stage, DAC stage, output switch
module pdl_chan
    import pdl_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          reset_i,
    input  wire pdl_chan_ctl_t ctl_i,
    output logic [11:0]        in_code_o,
    output logic [11:0]        dac_code_o,
    output logic [1:0]         pd_mode_o,
    output logic               amp_on_o,
    output logic               pull_1k_o,
    output logic               pull_100k_o,
    output logic               ready_o
);

    logic [`PDL_CNT_W-1:0] wake_q; // Cycles left until output settles

    // Input register stage
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            in_code_o <= `PDL_CODE_RESET;
        end else if (ctl_i.wr_input) begin
            in_code_o <= ctl_i.code;
        end
    end

    // DAC register stage, untouched by power mode changes
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dac_code_o <= `PDL_CODE_RESET;
        end else if (ctl_i.load_data) begin
            dac_code_o <= ctl_i.code;
        end else if (ctl_i.load_input) begin
            dac_code_o <= in_code_o;
        end
    end

    // Power mode and output switch selection
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pd_mode_o   <= `PDL_PD_NORMAL;
            amp_on_o    <= 1'b1;
            pull_1k_o   <= 1'b0;
            pull_100k_o <= 1'b0;
        end else if (ctl_i.pd_wr) begin
            pd_mode_o   <= ctl_i.pd_code;
            amp_on_o    <= (ctl_i.pd_code == `PDL_PD_NORMAL);
            pull_1k_o   <= (ctl_i.pd_code == `PDL_PD_1K);
            pull_100k_o <= (ctl_i.pd_code == `PDL_PD_100K);
        end
    end

    // Settling timer after return to normal mode
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wake_q  <= '0;
            ready_o <= 1'b1;
        end else if (ctl_i.pd_wr) begin
            if (ctl_i.pd_code != `PDL_PD_NORMAL) begin
                wake_q  <= '0;
                ready_o <= 1'b0;
            end else if (pd_mode_o != `PDL_PD_NORMAL) begin
                wake_q  <= `PDL_CNT_W'(`PDL_PWRUP_CYCLES);
                ready_o <= 1'b0;
            end
        end else if (wake_q != '0) begin
            wake_q  <= wake_q - `PDL_CNT_W'(1);
            ready_o <= (wake_q == `PDL_CNT_W'(1));
        end
    end

endmodule // pdl_chan

// ### hdl/pdl_pkg.sv
package pdl_pkg;

    // One decoded 24-bit command word
    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } pdl_frame_t;

    // Per-channel update request for one clock
    typedef struct packed {
        logic        wr_input;   // Data into input register
        logic        load_data;  // Data straight into DAC register
        logic        load_input; // Input register into DAC register
        logic        pd_wr;      // New power mode
        logic [1:0]  pd_code;    // Power mode value
        logic [11:0] code;       // Conversion code
    } pdl_chan_ctl_t;

endpackage

// ### hdl/pdl_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pins
module pdl_sync
    import pdl_pkg::*;
#(
    parameter int         W   = 2,
    parameter logic [1:0] RST = 2'h3
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);

    // One chain per bit
    for (genvar b = 0; b < W; b++) begin : g_bit
        logic meta_q; // First stage, read only by the second

        // Two flops per pin
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                meta_q    <= RST[b];
                sync_o[b] <= RST[b];
            end else begin
                meta_q    <= pin_i[b];
                sync_o[b] <= meta_q;
            end
        end
    end

endmodule // pdl_sync

// ### hdl/pdl_top.sv
`timescale 1ns/1ns
`include "pdl_cfg.svh"
module pdl_top
    import pdl_pkg::*;
(
    input  wire logic        ref_clk_i,       // Serial-side clock
    input  wire logic        reset_i,         // Synchronous reset, active high
    input  wire logic [23:0] frame_word_i,    // Completed 24-bit command word
    input  wire logic        frame_valid_i,   // One-cycle pulse at 24th bit
    input  wire logic        load_strobe_n_i, // Load strobe pin, asynchronous
    input  wire logic        hw_reset_n_i,    // Hardware reset pin, asynchronous
    output logic [11:0]      chan_a_code_o,   // Channel A DAC register
    output logic [11:0]      chan_b_code_o,   // Channel B DAC register
    output logic [11:0]      chan_a_input_o,  // Channel A input register
    output logic [11:0]      chan_b_input_o,  // Channel B input register
    output logic [1:0]       chan_a_pwr_mode_o, // Channel A power mode
    output logic [1:0]       chan_b_pwr_mode_o, // Channel B power mode
    output logic [1:0]       amp_on_o,        // Amplifier drives output, per channel
    output logic [1:0]       pull_1k_o,       // 1k network selected, per channel
    output logic [1:0]       pull_100k_o,     // 100k network selected, per channel
    output logic [1:0]       chan_ready_o,    // Output settled, per channel
    output logic [3:0]       load_strobe_mask_o, // Strobe mask register
    output logic             strobe_tied_o    // Strobe seen as tied low
);

    // Flow through the block:
    // both pins pass two flops,
    // the strobe gets an edge finder,
    // a long low strobe means tied,
    // each finished word is decoded
    // in the cycle its pulse is high,
    // and each channel then gets
    // one request for that clock.
    // Channel modules hold the codes
    // and modes, so every output
    // here comes from a flop.

    // Pin synchronisation
    logic [1:0] pins_s;        // Synchronised pins
    logic       strobe_s;      // Synchronised load strobe
    logic       hw_run_s;      // Synchronised reset pin, high when running
    logic       strobe_prev_q; // Strobe one clock earlier
    logic       strobe_fall;   // Falling edge of strobe

    // Command decoding
    pdl_frame_t frame;         // Fields of the incoming word
    logic [11:0] data_code;    // Conversion code in the word
    logic       is_wr_input;   // Write input register
    logic       is_upd_dac;    // Update DAC from input
    logic       is_wr_upd;     // Write and update
    logic       is_pwr;        // Power mode command
    logic       is_mask;       // Mask load command

    // Mask and tie detection
    logic [3:0]  mask_q;       // Strobe mask register
    logic [`PDL_CNT_W-1:0] tie_cnt_q; // Cycles strobe has stayed low
    logic        tied_q;       // Strobe judged tied low

    // Per-channel requests
    pdl_chan_ctl_t ctl [2];    // Request to each channel
    logic [11:0] in_code  [2]; // Input registers
    logic [11:0] dac_code [2]; // DAC registers
    logic [1:0]  pd_mode  [2]; // Power modes
    logic [1:0]  amp_on;       // Amplifier connect per channel
    logic [1:0]  pull_1k;      // 1k pulldown per channel
    logic [1:0]  pull_100k;    // 100k pulldown per channel
    logic [1:0]  ready;        // Settled per channel

    // Decoding helpers below are
    // used once per channel, so they
    // live in functions; index 0 is
    // channel A and index 1 is B.
    // Any index other than 0 maps
    // to channel B on purpose.
    // Field positions come from the
    // shared constants header only.

    // Channel address bit for a channel index
    function automatic logic chan_sel(input pdl_frame_t f, input int idx);
        logic [23:0] w;
        w = f;
        if (idx == 0) begin
            chan_sel = w[`PDL_ADDR_A_BIT];
        end else begin
            chan_sel = w[`PDL_ADDR_B_BIT];
        end
    endfunction

    // Mask bit for a channel index
    function automatic logic mask_bit(input logic [3:0] m, input int idx);
        if (idx == 0) begin
            mask_bit = m[`PDL_MASK_A_BIT];
        end else begin
            mask_bit = m[`PDL_MASK_B_BIT];
        end
    endfunction

    // Power mode field for a channel index
    function automatic logic [1:0] pd_field(input logic [15:0] d, input int idx);
        if (idx == 0) begin
            pd_field = d[`PDL_PD_A_LSB +: 2];
        end else begin
            pd_field = d[`PDL_PD_B_LSB +: 2];
        end
    endfunction

    // Hazard: both pins are async.
    // Only the second flop of each
    // chain feeds any logic, so a
    // metastable first stage never
    // reaches the decode paths.
    // Cost: pin changes are seen
    // two clocks late.
    // Reset value high matches the
    // idle level, so leaving reset
    // gives no false strobe edge.

    // Both pins idle high
    pdl_sync #(
        .W   (2),
        .RST (2'h3)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .pin_i     ({hw_reset_n_i, load_strobe_n_i}),
        .sync_o    (pins_s)
    );

    assign strobe_s = pins_s[0];
    assign hw_run_s = pins_s[1];

    // Edge finder for the strobe.
    // Starts high like the pin, so
    // no fall is seen after reset.
    // A fall is one clock long and
    // loads the DAC stage on the
    // next edge, three clocks after
    // the pin itself went low.
    // Falls while the reset pin is
    // low are dropped, not delayed.

    // Previous strobe level for edge detection
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= strobe_s;
        end
    end

    // Falling edge, ignored while held in hardware reset
    assign strobe_fall = strobe_prev_q & ~strobe_s & hw_run_s;

    // Tie detection.
    // A strobe held low for the tie
    // count is taken as wired low;
    // from then on the mask bits are
    // ignored and every write with
    // strobe low lands in both stages.
    // Any high level restarts the
    // count and clears the flag.
    // Limit: a very long pulse from
    // a host also counts as tied.

    // Strobe held low long enough counts as tied low
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tie_cnt_q <= '0;
            tied_q    <= 1'b0;
        end else if (strobe_s) begin
            tie_cnt_q <= '0;
            tied_q    <= 1'b0;
        end else if (tie_cnt_q != `PDL_CNT_W'(`PDL_TIE_CYCLES)) begin
            tie_cnt_q <= tie_cnt_q + `PDL_CNT_W'(1);
        end else begin
            tied_q <= 1'b1;
        end
    end

    // Field extraction
    assign frame     = pdl_frame_t'(frame_word_i);
    assign data_code = frame_word_i[`PDL_DATA_MSB:`PDL_DATA_LSB];

    // Decode strobes.
    // Each is high for exactly the
    // one clock of the word pulse,
    // so no request can repeat from
    // an old word left on the bus.
    // Unused codes match no strobe
    // and the word is dropped.
    // Words may come every clock.

    // Command decode, valid only with a completed word
    assign is_wr_input = frame_valid_i & (frame.cmd == `PDL_CMD_WR_INPUT);
    assign is_upd_dac  = frame_valid_i & (frame.cmd == `PDL_CMD_UPD_DAC);
    assign is_wr_upd   = frame_valid_i & (frame.cmd == `PDL_CMD_WR_UPD);
    assign is_pwr      = frame_valid_i & (frame.cmd == `PDL_CMD_PWR_MODE);
    assign is_mask     = frame_valid_i & (frame.cmd == `PDL_CMD_LOAD_MASK);

    // Mask register.
    // Bit 0 guards channel A and
    // bit 3 guards channel B; the
    // middle bits are kept only so
    // the register reads back whole.
    // Not blocked by the reset pin,
    // which only gates DAC and mode loads.

    // Mask register, address field ignored
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mask_q <= `PDL_MASK_RESET;
        end else if (is_mask) begin
            mask_q <= frame.data[3:0];
        end
    end

    // Per-channel requests.
    // Priority inside a channel:
    // a code from the word beats a
    // copy from the input stage, so
    // a write and a strobe fall in
    // one clock keep the new code.
    // Power requests go to both
    // channels at once; each takes
    // its own two-bit field, so one
    // word always sets both.
    // The reset pin gates every DAC
    // load and mode change here.

    // Per-channel request building and channel instances
    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic sel;        // Channel addressed by the word
        logic masked;     // Channel ignores the strobe pin
        logic strobe_low; // Strobe as seen by this channel

        assign sel        = chan_sel(frame, i);
        assign masked     = mask_bit(mask_q, i) & ~tied_q;
        assign strobe_low = ~strobe_s & ~masked;

        // Request for this channel on this clock
        always_comb begin
            ctl[i] = '0;
            ctl[i].code = data_code;
            // Input stage written by 0001 and 0011
            ctl[i].wr_input = sel & (is_wr_input | is_wr_upd);
            // DAC stage from word: 0011 always, 0001 with strobe low
            ctl[i].load_data = hw_run_s & sel &
                               (is_wr_upd | (is_wr_input & strobe_low));
            // DAC stage from input: 0010 or strobe edge on unmasked channel
            ctl[i].load_input = hw_run_s &
                                ((sel & is_upd_dac) | (strobe_fall & ~masked));
            // Power mode per channel, each from its own field
            ctl[i].pd_wr   = is_pwr & hw_run_s;
            ctl[i].pd_code = pd_field(frame.data, i);
        end

        // Channel storage.
        // Holds input and DAC stages,
        // the power mode, the output
        // switch lines and the settle
        // timer after power-up.
        // All of its outputs are flops.
        pdl_chan u_chan (
            .ref_clk_i   (ref_clk_i),
            .reset_i     (reset_i),
            .ctl_i       (ctl[i]),
            .in_code_o   (in_code[i]),
            .dac_code_o  (dac_code[i]),
            .pd_mode_o   (pd_mode[i]),
            .amp_on_o    (amp_on[i]),
            .pull_1k_o   (pull_1k[i]),
            .pull_100k_o (pull_100k[i]),
            .ready_o     (ready[i])
        );
    end

    // Output wiring.
    // No logic sits between these
    // flops and the ports, so the
    // host sees a word's changes,
    // all but the ready rise, one clock after it.
    // Index 0 is channel A and
    // index 1 is channel B in all
    // of the two-bit vectors.
    // The mask and tie flag are
    // shown for test and debug.

    // Outputs come from the channel, mask and tie registers directly
    assign chan_a_code_o     = dac_code[0];
    assign chan_b_code_o     = dac_code[1];
    assign chan_a_input_o    = in_code[0];
    assign chan_b_input_o    = in_code[1];
    assign chan_a_pwr_mode_o = pd_mode[0];
    assign chan_b_pwr_mode_o = pd_mode[1];
    assign amp_on_o          = amp_on;
    assign pull_1k_o         = pull_1k;
    assign pull_100k_o       = pull_100k;
    assign chan_ready_o      = ready;
    assign load_strobe_mask_o = mask_q;
    assign strobe_tied_o     = tied_q;

endmodule // pdl_top

// ### sim/pdl_host.sv
`timescale 1ns/1ns
// Bus master stand-in: hands whole frames to the block
module pdl_host
    import pdl_pkg::*;
(
    input  wire logic        ref_clk_i,    // Block clock
    output logic      [23:0] frame_word_o, // Assembled frame
    output logic             frame_valid_o // Word complete pulse
);
    // Idle at start
    initial begin
        frame_word_o  = 24'h000000;
        frame_valid_o = 1'b0;
    end
    // One frame: command byte, high byte, low byte
    task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        logic [23:0] w;
        w = {c, a, d};
        if (c == 4'h4) begin
            w[5:2] = 4'hF;
        end
        @(posedge ref_clk_i);
        frame_word_o  <= w;
        frame_valid_o <= 1'b1;
        @(posedge ref_clk_i);
        frame_word_o  <= ~w; // Stale word never lingers
        frame_valid_o <= 1'b0;
    endtask
endmodule // pdl_host

// ### sim/pdl_top_props.sv
`timescale 1ns/1ns
// Port-level checks of the power and load control block
module pdl_top_props
    import pdl_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic [23:0] frame_word_i,
    input  wire logic        frame_valid_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        hw_reset_n_i,
    input  wire logic [11:0] chan_a_code_o,
    input  wire logic [11:0] chan_b_code_o,
    input  wire logic [11:0] chan_a_input_o,
    input  wire logic [11:0] chan_b_input_o,
    input  wire logic [1:0]  chan_a_pwr_mode_o,
    input  wire logic [1:0]  chan_b_pwr_mode_o,
    input  wire logic [1:0]  amp_on_o,
    input  wire logic [1:0]  pull_1k_o,
    input  wire logic [1:0]  pull_100k_o,
    input  wire logic [1:0]  chan_ready_o,
    input  wire logic [3:0]  load_strobe_mask_o,
    input  wire logic        strobe_tied_o
);
    logic [2:0] hw_q;  // Reset pin history
    logic [2:0] stb_q; // Strobe pin history
    logic       hw_ok; // Reset pin settled high
    logic       hi;    // Strobe settled high
    logic [3:0] cmd;   // Command nibble
    logic       fa;    // Frame addresses channel A
    assign hw_ok = hw_reset_n_i && (&hw_q);
    assign hi    = load_strobe_n_i && (&stb_q);
    assign cmd   = frame_word_i[23:20];
    assign fa    = frame_valid_i && frame_word_i[16];
    // Pin histories cover the synchroniser delay
    always_ff @(posedge ref_clk_i) begin
        hw_q  <= {hw_q[1:0], hw_reset_n_i};
        stb_q <= {stb_q[1:0], load_strobe_n_i};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    chk_pwr_mode_load: assert property (frame_valid_i && cmd == 4'h4 && hw_ok |=>
        chan_a_pwr_mode_o == $past(frame_word_i[1:0])
        && chan_b_pwr_mode_o == $past(frame_word_i[7:6])) else $error("power mode load");
    chk_mode_decode: assert property (amp_on_o == {!chan_b_pwr_mode_o, !chan_a_pwr_mode_o}
        && pull_1k_o == {chan_b_pwr_mode_o == 2'h1, chan_a_pwr_mode_o == 2'h1}
        && pull_100k_o == {chan_b_pwr_mode_o == 2'h2, chan_a_pwr_mode_o == 2'h2})
        else $error("output switch decode");
    chk_pd_keeps_code: assert property (frame_valid_i && cmd == 4'h4 && hi |=>
        $stable(chan_a_code_o) && $stable(chan_b_code_o)) else $error("code moved");
    chk_mask_load: assert property (frame_valid_i && cmd == 4'h5 |=>
        load_strobe_mask_o == $past(frame_word_i[3:0])) else $error("mask load");
    chk_reset_values: assert property ($fell(reset_i) |-> load_strobe_mask_o == 4'h0
        && chan_a_pwr_mode_o == 2'h0 && chan_b_pwr_mode_o == 2'h0) else $error("reset values");
    chk_wr_upd_both: assert property (frame_valid_i && cmd == 4'h3 && frame_word_i[19] && hw_ok
        |=> chan_b_code_o == $past(frame_word_i[15:4]) && chan_b_input_o == chan_b_code_o)
        else $error("write and update");
    chk_wr_input_only: assert property (fa && cmd == 4'h1 && hi |=> $stable(chan_a_code_o)
        && chan_a_input_o == $past(frame_word_i[15:4])) else $error("input write");
    chk_strobe_fall: assert property ($fell(load_strobe_n_i) && !load_strobe_mask_o[0] && hw_ok
        ##1 (!load_strobe_n_i && !frame_valid_i)[*5] |-> chan_a_code_o == chan_a_input_o)
        else $error("strobe load");
    chk_masked_strobe: assert property ($fell(load_strobe_n_i) && load_strobe_mask_o[0]
        && !strobe_tied_o ##1 (!load_strobe_n_i && !frame_valid_i)[*5]
        |-> chan_a_code_o == $past(chan_a_code_o, 5)) else $error("masked strobe");
    chk_tied_low: assert property (fa && cmd == 4'h1 && strobe_tied_o && hw_ok |=>
        chan_a_code_o == $past(frame_word_i[15:4])) else $error("tied strobe");
    chk_pin_blocks: assert property (fa && cmd == 4'h3 && !hw_reset_n_i && !(|hw_q) |=>
        $stable(chan_a_code_o)) else $error("reset pin");
endmodule // pdl_top_props

bind pdl_top pdl_top_props i_props (
    .ref_clk_i, .reset_i, .frame_word_i, .frame_valid_i, .load_strobe_n_i, .hw_reset_n_i,
    .chan_a_code_o, .chan_b_code_o, .chan_a_input_o, .chan_b_input_o, .chan_a_pwr_mode_o,
    .chan_b_pwr_mode_o, .amp_on_o, .pull_1k_o, .pull_100k_o, .chan_ready_o,
    .load_strobe_mask_o, .strobe_tied_o
);

// ### sim/pdl_top_test.sv
`timescale 1ns/1ns
// Self-checking bench of the power and load control block
module pdl_top_test
    import pdl_pkg::*;
;
    logic        ref_clk_i;       // Block clock
    logic        reset_i;         // Synchronous reset
    logic        load_strobe_n_i; // Load strobe pin
    logic        hw_reset_n_i;    // Reset pin
    logic [23:0] word;            // Frame from host
    logic        valid;           // Frame pulse
    logic [11:0] code_a, code_b, in_a, in_b; // Register stages
    logic [1:0]  mode_a, mode_b, amp_on, p1k, p100k, ready; // Output stage
    logic [3:0]  mask;            // Strobe mask
    logic        tied;            // Strobe tied low
    int          num_errors = 0;  // Mismatches
    int          n_tests = 0;     // Comparisons
    int          cycles = 0;      // Run length
    pdl_host i_host (.ref_clk_i, .frame_word_o(word), .frame_valid_o(valid));
    pdl_top i_dut (
        .ref_clk_i, .reset_i, .frame_word_i(word), .frame_valid_i(valid),
        .load_strobe_n_i, .hw_reset_n_i, .chan_a_code_o(code_a), .chan_b_code_o(code_b),
        .chan_a_input_o(in_a), .chan_b_input_o(in_b), .chan_a_pwr_mode_o(mode_a),
        .chan_b_pwr_mode_o(mode_b), .amp_on_o(amp_on), .pull_1k_o(p1k),
        .pull_100k_o(p100k), .chan_ready_o(ready), .load_strobe_mask_o(mask),
        .strobe_tied_o(tied)
    );
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Send a frame and settle past its answer edge
    task automatic snd(logic [3:0] c, logic [3:0] a, logic [15:0] d);
        i_host.send(c, a, d);
        @(negedge ref_clk_i);
    endtask
    // Move the strobe pin and let the synchroniser pass it
    task automatic strobe(logic v);
        @(posedge ref_clk_i);
        load_strobe_n_i <= v;
        cyc(6);
        @(negedge ref_clk_i);
    endtask
    task automatic t_reset();
        chk("mask", mask, 4'h0);
        chk("mode_a", mode_a, 2'h0);
        chk("mode_b", mode_b, 2'h0);
        chk("amp_on", amp_on, 2'h3);
    endtask
    task automatic t_write();
        snd(4'h3, 4'h9, 16'hABC0);
        chk("code_a", code_a, 12'hABC);
        chk("in_b", in_b, 12'hABC);
        snd(4'h1, 4'h1, 16'h1230);
        chk("in_a", in_a, 12'h123);
        chk("code_a", code_a, 12'hABC);
        strobe(1'b0);
        chk("code_a", code_a, 12'h123);
        snd(4'h1, 4'h8, 16'h4560);
        chk("code_b", code_b, 12'h456);
        strobe(1'b1);
    endtask
    task automatic t_cmd2();
        snd(4'h1, 4'h1, 16'h7E10);
        snd(4'h2, 4'h1, 16'h0000);
        chk("code_a", code_a, 12'h7E1);
        chk("in_a", in_a, 12'h7E1);
        chk("code_b", code_b, 12'h456);
    endtask
    task automatic t_power();
        logic [1:0] a;
        logic [1:0] b;
        for (int m = 0; m < 4; m++) begin
            b = 2'(m);
            a = 2'(3 - m);
            snd(4'h4, 4'h0, {8'h00, b, 4'h0, a});
            chk("mode_a", mode_a, a);
            chk("mode_b", mode_b, b);
            chk("amp_on", amp_on, {b == 2'h0, a == 2'h0});
            chk("pull_1k", p1k, {b == 2'h1, a == 2'h1});
            chk("pull_100k", p100k, {b == 2'h2, a == 2'h2});
            chk("code_a", code_a, 12'h7E1);
        end
        snd(4'h3, 4'h8, 16'h5A50);
        chk("code_b", code_b, 12'h5A5);
        chk("ready_a", ready[0], 1'b0);
        cyc(570);
        @(negedge ref_clk_i);
        chk("ready_a", ready[0], 1'b1);
        snd(4'h4, 4'h0, 16'h0000);
        cyc(570);
    endtask
    task automatic t_mask();
        snd(4'h5, 4'hF, 16'h0009);
        chk("mask", mask, 4'h9);
        snd(4'h1, 4'h1, 16'h1110);
        strobe(1'b0);
        chk("code_a", code_a, 12'h7E1);
        cyc(260);
        @(negedge ref_clk_i);
        chk("tied", tied, 1'b1);
        snd(4'h1, 4'h1, 16'h2220);
        chk("code_a", code_a, 12'h222);
        strobe(1'b1);
        snd(4'h5, 4'h0, 16'h0000);
    endtask
    task automatic t_pin();
        @(posedge ref_clk_i);
        hw_reset_n_i <= 1'b0;
        cyc(4);
        snd(4'h3, 4'h1, 16'h3330);
        chk("code_a", code_a, 12'h222);
        snd(4'h4, 4'h0, 16'h0001);
        chk("mode_a", mode_a, 2'h0);
        @(posedge ref_clk_i);
        hw_reset_n_i <= 1'b1;
        cyc(4);
    endtask
    // Clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // Hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        reset_i = 1'b1;
        load_strobe_n_i = 1'b1;
        hw_reset_n_i = 1'b1;
        cyc(8);
        reset_i <= 1'b0;
        @(negedge ref_clk_i);
        t_reset();
        t_write();
        t_cmd2();
        t_power();
        t_mask();
        t_pin();
        summarize();
    end
endmodule // pdl_top_test
